// *** src/timer_pkg.sv ***
// Purpose: Shared constants and types for the four-timer block
// Assumes: 32-bit APB, 256-byte window, each timer owns 64 bytes
// Notes:   Offsets are byte offsets inside one timer's window
package timer_pkg;

  // ==========================================================================
  // Structure
  localparam int NUM_TIMERS   = 4;
  localparam int ADV_INDEX    = 0;
  localparam int CH_NUM       = 4;
  localparam int PAIR_NUM     = 3;
  localparam int SYNC_W       = 21;
  localparam int EVT_W        = 6;

  // ==========================================================================
  // Register offsets inside one timer window
  localparam logic [5:0] OFS_CTRL     = 6'h00;
  localparam logic [5:0] OFS_PSC      = 6'h04;
  localparam logic [5:0] OFS_ARR      = 6'h08;
  localparam logic [5:0] OFS_CNT      = 6'h0c;
  localparam logic [5:0] OFS_CCR0     = 6'h10;
  localparam logic [5:0] OFS_CCR1     = 6'h14;
  localparam logic [5:0] OFS_CCR2     = 6'h18;
  localparam logic [5:0] OFS_CCR3     = 6'h1c;
  localparam logic [5:0] OFS_CCMODE   = 6'h20;
  localparam logic [5:0] OFS_DEADTIME = 6'h24;
  localparam logic [5:0] OFS_IDLE     = 6'h28;
  localparam logic [5:0] OFS_STATUS   = 6'h30;
  localparam logic [5:0] OFS_MASK     = 6'h34;

  // ==========================================================================
  // Control register fields
  localparam int CTRL_EN        = 0;
  localparam int CTRL_DIR_LSB   = 1;
  localparam int CTRL_SLAVE_LSB = 3;
  localparam int CTRL_TRIG_SEL  = 5;
  localparam int CTRL_FREEZE    = 6;
  localparam int CTRL_DMA_UPD   = 7;
  localparam int CTRL_DMA_CC    = 8;
  localparam int CTRL_MOE       = 12;
  localparam int CTRL_BRK_POL   = 13;
  localparam int CTRL_BRK_EN    = 14;

  // Channel mode nibble: mode in bits 1:0, then polarity, then output enable
  localparam int CCM_POL        = 2;
  localparam int CCM_OE         = 3;

  // Event and status bit positions
  localparam int EVT_UPD        = 0;
  localparam int EVT_CC_LSB     = 1;
  localparam int EVT_BRK        = 5;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] PSC_RST  = 16'h0000;
  localparam logic [15:0] ARR_RST  = 16'hffff;
  localparam logic [15:0] CCR_RST  = 16'h0000;
  localparam logic [15:0] CCM_RST  = 16'h0000;
  localparam logic [7:0]  DT_RST   = 8'h00;
  localparam logic [5:0]  IDLE_RST = 6'h00;

  // ==========================================================================
  // Modes
  typedef enum logic [1:0] {DIR_UP, DIR_DOWN, DIR_CENTRE, DIR_SPARE} dir_mode_type;
  typedef enum logic [1:0] {SLV_FREE, SLV_TRIG_START, SLV_GATED, SLV_EXT_CLOCK} slave_mode_type;
  typedef enum logic [1:0] {CC_OFF, CC_PWM, CC_CAP_RISE, CC_CAP_FALL} cc_mode_type;

endpackage : timer_pkg

// *** src/dead_band_unit.sv ***
// Purpose: Complementary output pair with dead band from one PWM reference
// Assumes: Reference comes from logic on the same clock
// Notes:   A dead time of zero gives plain complementary outputs
`timescale 1ns/100ps
`default_nettype none
module dead_band_unit (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  // Reference and delay
  input  wire logic       ref_i,
  input  wire logic [7:0] dead_i,
  // Pair outputs
  output logic            main_o,
  output logic            comp_o
);

  logic [7:0] dly_cnt_ff;
  logic       ref_d_ff;
  logic       settled;

  // ==========================================================================
  // Delay counter, restarted on every reference edge
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dly_cnt_ff <= 8'h00;
      ref_d_ff   <= 1'b0;
    end else begin
      ref_d_ff <= ref_i;
      if (ref_i != ref_d_ff) begin
        dly_cnt_ff <= 8'h01;
      end else if (dly_cnt_ff != 8'hff) begin
        dly_cnt_ff <= dly_cnt_ff + 8'h01;
      end
    end
  end

  // Both outputs stay low until the delay has run out after an edge
  assign settled = (ref_i != ref_d_ff) ? (dead_i == 8'h00) : (dly_cnt_ff >= dead_i);

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      main_o <= 1'b0;
      comp_o <= 1'b0;
    end else begin
      main_o <= ref_i & settled; // RQ5
      comp_o <= ~ref_i & settled; // RQ5
    end
  end

endmodule : dead_band_unit
`default_nettype wire

// *** src/advanced_and_general_timer.sv ***
// Purpose: One advanced and three general 16-bit timers behind an APB slave
// Assumes: All pins asynchronous to mclk_i; debug halt comes from core logic
// Notes:   Timer 0 is the advanced timer; chain input of timer n is trgo of n-1, and timer 0 takes trgo of timer 3
// Notes on behaviour
// [RQ1] Every timer has a 16-bit counter counting up, down or centre-aligned.
// [RQ2] Prescaler divides the counter clock by any integer from 1 to 65536.
// [RQ3] General timers have one trigger input and four plain channel pins.
// [RQ4] Advanced timer has trigger, break, three pairs and one single channel.
// [RQ5] Advanced pairs are complementary with programmable dead band between them.
// [RQ6] Advanced timer offers everything a general timer offers.
// [RQ7] PWM duty runs the full range from 0 to 100 percent.
// [RQ8] Debug halt with freeze stops the counter and disables advanced outputs.
// [RQ9] Timers synchronise and chain: one trigger output starts or clocks another.
// [RQ10] Each timer raises its own DMA request on update and channel events.
// [RQ11] Active break input forces advanced outputs to their configured idle state.
`timescale 1ns/100ps
`default_nettype none
module advanced_and_general_timer (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Timer pins, channel k of timer t at index 4*t+k
  input  wire logic [3:0]  etr_i,
  input  wire logic        brk_i,
  input  wire logic [15:0] ch_i,
  output logic      [15:0] ch_o,
  output logic      [15:0] ch_oe_o,
  output logic      [2:0]  chn_o,
  // System
  input  wire logic        dbg_halt_i,
  output logic      [3:0]  trgo_o,
  output logic      [3:0]  dma_req_o,
  output logic             irq_o
);

  localparam int NT  = timer_pkg::NUM_TIMERS;
  localparam int ADV = timer_pkg::ADV_INDEX;

  // ==========================================================================
  // Pin synchronisers
  logic [timer_pkg::SYNC_W-1:0] sync1_ff;
  logic [timer_pkg::SYNC_W-1:0] sync2_ff;
  logic [3:0]                   etr_s;
  logic [15:0]                  ch_s;
  logic                         brk_s;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {brk_i, ch_i, etr_i};
      sync2_ff <= sync1_ff;
    end
  end

  assign etr_s = sync2_ff[3:0];
  assign ch_s  = sync2_ff[19:4];
  assign brk_s = sync2_ff[20];

  // ==========================================================================
  // APB decode; zero wait states
  logic [1:0]  sel_tmr;
  logic [5:0]  sel_ofs;
  logic        reg_ok;
  logic        acc;
  logic        wr_acc;
  logic        rd_acc;
  logic        setup;
  logic [31:0] prdata_ff;
  logic [31:0] rd_word [NT];
  logic [NT-1:0] irq_src;
  logic [NT-1:0] trgo_w;
  logic        irq_ff;

  assign sel_tmr = paddr_i[7:6];
  assign sel_ofs = paddr_i[5:0];

  always_comb begin
    case (sel_ofs)
      timer_pkg::OFS_CTRL, timer_pkg::OFS_PSC, timer_pkg::OFS_ARR, timer_pkg::OFS_CNT,
      timer_pkg::OFS_CCR0, timer_pkg::OFS_CCR1, timer_pkg::OFS_CCR2, timer_pkg::OFS_CCR3,
      timer_pkg::OFS_CCMODE, timer_pkg::OFS_DEADTIME, timer_pkg::OFS_IDLE,
      timer_pkg::OFS_STATUS, timer_pkg::OFS_MASK: reg_ok = 1'b1;
      default: reg_ok = 1'b0;
    endcase
  end

  assign acc       = psel_i & penable_i;
  assign wr_acc    = acc & pwrite_i & reg_ok;
  assign rd_acc    = acc & ~pwrite_i & reg_ok;
  assign setup     = psel_i & ~penable_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = acc & ~reg_ok;
  assign prdata_o  = prdata_ff;
  assign irq_o     = irq_ff;

  // Read data is caught in the setup cycle; status clear uses this same value
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup) begin
      prdata_ff <= (!pwrite_i && reg_ok) ? rd_word[sel_tmr] : 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |irq_src;
    end
  end

  // ==========================================================================
  // Timers
  for (genvar t = 0; t < NT; t++) begin : g_tmr
    logic [15:0] ctrl_ff;
    logic [15:0] psc_ff;
    logic [15:0] arr_ff;
    logic [15:0] cnt_ff;
    logic [15:0] psc_cnt_ff;
    logic [15:0] ccm_ff;
    logic [15:0] ccr_ff [timer_pkg::CH_NUM];
    logic [7:0]  dt_ff;
    logic [5:0]  idle_ff;
    logic [5:0]  status_ff;
    logic [5:0]  mask_ff;
    logic        up_ff;
    logic        run_ff;
    logic        trig_d_ff;
    logic        trgo_ff;
    logic        dma_ff;
    logic [3:0]  cap_d_ff;
    logic [3:0]  out_ff;
    logic [3:0]  oe_ff;
    logic [2:0]  comp_ff;
    logic        wr_t;
    logic        trig;
    logic        trig_rise;
    logic        frozen;
    logic        run_ok;
    logic        presc_step;
    logic        count_en;
    logic        tick;
    logic        upd;
    logic        nxt_up;
    logic [15:0] nxt_cnt;
    logic        brk_now;
    logic        out_en;
    logic [3:0]  cap_s;
    logic [3:0]  cap_evt;
    logic [3:0]  cmp_evt;
    logic [3:0]  ref_w;
    logic [3:0]  main_w;
    logic [2:0]  comp_w;
    logic [5:0]  evt;
    logic [31:0] rd_t;

    assign wr_t  = wr_acc & (sel_tmr == 2'(t));
    assign cap_s = ch_s[4*t +: 4];
    assign trig  = ctrl_ff[timer_pkg::CTRL_TRIG_SEL] ? trgo_w[(t + NT - 1) % NT] : etr_s[t]; // RQ9
    assign trig_rise = trig & ~trig_d_ff;
    assign frozen    = dbg_halt_i & ctrl_ff[timer_pkg::CTRL_FREEZE]; // RQ8

    // Configuration registers; break clears main output enable after any write
    always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        ctrl_ff <= timer_pkg::CTRL_RST;
        psc_ff  <= timer_pkg::PSC_RST;
        arr_ff  <= timer_pkg::ARR_RST;
        ccm_ff  <= timer_pkg::CCM_RST;
        dt_ff   <= timer_pkg::DT_RST;
        idle_ff <= timer_pkg::IDLE_RST;
        mask_ff <= 6'h00;
      end else begin
        if (wr_t) begin
          case (sel_ofs)
            timer_pkg::OFS_CTRL:     ctrl_ff <= pwdata_i[15:0];
            timer_pkg::OFS_PSC:      psc_ff  <= pwdata_i[15:0];
            timer_pkg::OFS_ARR:      arr_ff  <= pwdata_i[15:0];
            timer_pkg::OFS_CCMODE:   ccm_ff  <= pwdata_i[15:0];
            timer_pkg::OFS_DEADTIME: dt_ff   <= pwdata_i[7:0];
            timer_pkg::OFS_IDLE:     idle_ff <= pwdata_i[5:0];
            timer_pkg::OFS_MASK:     mask_ff <= pwdata_i[5:0];
            default: ;
          endcase
        end
        if (brk_now) ctrl_ff[timer_pkg::CTRL_MOE] <= 1'b0; // RQ11
      end
    end

    // Slave modes: free, start on trigger, gated, clocked by trigger edges
    always_comb begin
      presc_step = 1'b1;
      case (timer_pkg::slave_mode_type'(ctrl_ff[timer_pkg::CTRL_SLAVE_LSB +: 2]))
        timer_pkg::SLV_FREE:       run_ok = 1'b1;
        timer_pkg::SLV_TRIG_START: run_ok = run_ff; // RQ9
        timer_pkg::SLV_GATED:      run_ok = trig; // RQ9
        timer_pkg::SLV_EXT_CLOCK: begin
          run_ok     = 1'b1;
          presc_step = trig_rise; // RQ9
        end
        default:                   run_ok = 1'b1;
      endcase
      count_en = ctrl_ff[timer_pkg::CTRL_EN] & ~frozen & run_ok; // RQ8
    end

    // Prescaler ratio is psc_ff + 1, so 1 to 65536
    assign tick = count_en & presc_step & (psc_cnt_ff >= psc_ff); // RQ2

    always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        psc_cnt_ff <= 16'h0000;
        run_ff     <= 1'b0;
        trig_d_ff  <= 1'b0;
      end else begin
        trig_d_ff <= trig;
        if (count_en && presc_step) begin
          psc_cnt_ff <= (psc_cnt_ff >= psc_ff) ? 16'h0000 : psc_cnt_ff + 16'h0001; // RQ2
        end
        if (!ctrl_ff[timer_pkg::CTRL_EN]) run_ff <= 1'b0;
        else if (trig_rise) run_ff <= 1'b1;
      end
    end

    always_comb begin
      nxt_cnt = cnt_ff;
      nxt_up  = up_ff;
      upd     = 1'b0;
      if (tick) begin
        case (timer_pkg::dir_mode_type'(ctrl_ff[timer_pkg::CTRL_DIR_LSB +: 2]))
          timer_pkg::DIR_DOWN: begin
            upd     = (cnt_ff == 16'h0000); // RQ1
            nxt_cnt = upd ? arr_ff : cnt_ff - 16'h0001;
          end
          timer_pkg::DIR_CENTRE: begin
            if (up_ff) begin
              if (cnt_ff >= arr_ff) begin
                upd     = 1'b1; // RQ1
                nxt_up  = 1'b0;
                nxt_cnt = (arr_ff == 16'h0000) ? 16'h0000 : cnt_ff - 16'h0001;
              end else begin
                nxt_cnt = cnt_ff + 16'h0001;
              end
            end else if (cnt_ff == 16'h0000) begin
              upd     = 1'b1;
              nxt_up  = 1'b1;
              nxt_cnt = (arr_ff == 16'h0000) ? 16'h0000 : 16'h0001;
            end else begin
              nxt_cnt = cnt_ff - 16'h0001;
            end
          end
          default: begin
            upd     = (cnt_ff >= arr_ff); // RQ1
            nxt_cnt = upd ? 16'h0000 : cnt_ff + 16'h0001;
          end
        endcase
      end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        cnt_ff <= 16'h0000;
        up_ff  <= 1'b1;
      end else begin
        up_ff <= nxt_up;
        if (wr_t && sel_ofs == timer_pkg::OFS_CNT) cnt_ff <= pwdata_i[15:0];
        else cnt_ff <= nxt_cnt; // RQ1
      end
    end

    always_comb begin
      for (int c = 0; c < timer_pkg::CH_NUM; c++) begin
        case (timer_pkg::cc_mode_type'(ccm_ff[4*c +: 2]))
          timer_pkg::CC_CAP_RISE: cap_evt[c] = cap_s[c] & ~cap_d_ff[c];
          timer_pkg::CC_CAP_FALL: cap_evt[c] = ~cap_s[c] & cap_d_ff[c];
          default:                cap_evt[c] = 1'b0;
        endcase
        cmp_evt[c] = (timer_pkg::cc_mode_type'(ccm_ff[4*c +: 2]) == timer_pkg::CC_PWM) &
                     tick & (cnt_ff == ccr_ff[c]);
        // Compare zero gives 0 %, compare above reload gives 100 %
        ref_w[c] = (timer_pkg::cc_mode_type'(ccm_ff[4*c +: 2]) == timer_pkg::CC_PWM) &
                   ((cnt_ff < ccr_ff[c]) ^ ccm_ff[4*c + timer_pkg::CCM_POL]); // RQ7
      end
    end

    // Capture wins over a software write in the same cycle
    always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        for (int c = 0; c < timer_pkg::CH_NUM; c++) ccr_ff[c] <= timer_pkg::CCR_RST;
        cap_d_ff <= 4'h0;
      end else begin
        cap_d_ff <= cap_s;
        for (int c = 0; c < timer_pkg::CH_NUM; c++) begin
          if (cap_evt[c]) begin
            ccr_ff[c] <= cnt_ff; // RQ3
          end else if (wr_t && sel_ofs == timer_pkg::OFS_CCR0 + 6'(4*c)) begin
            ccr_ff[c] <= pwdata_i[15:0];
          end
        end
      end
    end

    // Dead band only on the advanced timer's first three channels
    for (genvar c = 0; c < timer_pkg::CH_NUM; c++) begin : g_ch
      if (t == ADV && c < timer_pkg::PAIR_NUM) begin : g_pair
        dead_band_unit u_dead (
          .mclk_i (mclk_i),
          .nrst_i (nrst_i),
          .ref_i  (ref_w[c]),
          .dead_i (dt_ff),
          .main_o (main_w[c]),
          .comp_o (comp_w[c])
        ); // RQ5
      end else begin : g_single
        assign main_w[c] = ref_w[c];
      end
    end
    if (t != ADV) begin : g_no_comp
      assign comp_w = 3'h0;
    end

    assign brk_now = (t == ADV) & ctrl_ff[timer_pkg::CTRL_BRK_EN] &
                     (brk_s == ctrl_ff[timer_pkg::CTRL_BRK_POL]); // RQ11
    // General timers keep driving while frozen; only the advanced one is gated
    assign out_en = (t != ADV) |
                    (ctrl_ff[timer_pkg::CTRL_MOE] & ~frozen & ~brk_now); // RQ8 RQ11
    assign evt = {brk_now & ctrl_ff[timer_pkg::CTRL_MOE], cap_evt | cmp_evt, upd};

    always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        out_ff  <= 4'h0;
        oe_ff   <= 4'h0;
        comp_ff <= 3'h0;
        trgo_ff <= 1'b0;
        dma_ff  <= 1'b0;
      end else begin
        for (int c = 0; c < timer_pkg::CH_NUM; c++) begin
          out_ff[c] <= out_en ? main_w[c] : idle_ff[c]; // RQ6
          oe_ff[c]  <= ccm_ff[4*c + timer_pkg::CCM_OE] &
                       (timer_pkg::cc_mode_type'(ccm_ff[4*c +: 2]) == timer_pkg::CC_PWM); // RQ4
        end
        comp_ff <= out_en ? comp_w : idle_ff[5:3]; // RQ11
        trgo_ff <= upd; // RQ9
        dma_ff  <= (upd & ctrl_ff[timer_pkg::CTRL_DMA_UPD]) |
                   (|((cap_evt | cmp_evt) & ctrl_ff[timer_pkg::CTRL_DMA_CC +: 4])); // RQ10
      end
    end

    // Sticky status; a read clears only the bits it returned, so events win
    always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        status_ff <= 6'h00;
      end else if (rd_acc && sel_tmr == 2'(t) && sel_ofs == timer_pkg::OFS_STATUS) begin
        status_ff <= evt | (status_ff & ~prdata_ff[5:0]);
      end else begin
        status_ff <= status_ff | evt;
      end
    end

    always_comb begin
      case (sel_ofs)
        timer_pkg::OFS_CTRL:     rd_t = {16'h0000, ctrl_ff};
        timer_pkg::OFS_PSC:      rd_t = {16'h0000, psc_ff};
        timer_pkg::OFS_ARR:      rd_t = {16'h0000, arr_ff};
        timer_pkg::OFS_CNT:      rd_t = {16'h0000, cnt_ff};
        timer_pkg::OFS_CCR0:     rd_t = {16'h0000, ccr_ff[0]};
        timer_pkg::OFS_CCR1:     rd_t = {16'h0000, ccr_ff[1]};
        timer_pkg::OFS_CCR2:     rd_t = {16'h0000, ccr_ff[2]};
        timer_pkg::OFS_CCR3:     rd_t = {16'h0000, ccr_ff[3]};
        timer_pkg::OFS_CCMODE:   rd_t = {16'h0000, ccm_ff};
        timer_pkg::OFS_DEADTIME: rd_t = {24'h000000, dt_ff};
        timer_pkg::OFS_IDLE:     rd_t = {26'h0000000, idle_ff};
        timer_pkg::OFS_STATUS:   rd_t = {26'h0000000, status_ff};
        timer_pkg::OFS_MASK:     rd_t = {26'h0000000, mask_ff};
        default:                 rd_t = 32'h0000_0000;
      endcase
    end

    assign rd_word[t]        = rd_t;
    assign irq_src[t]        = |(status_ff & mask_ff);
    assign trgo_w[t]         = trgo_ff;
    assign trgo_o[t]         = trgo_ff;
    assign dma_req_o[t]      = dma_ff;
    assign ch_o[4*t +: 4]    = out_ff; // RQ3
    assign ch_oe_o[4*t +: 4] = oe_ff;
    if (t == ADV) begin : g_comp_out
      assign chn_o = comp_ff; // RQ4
    end
  end

endmodule : advanced_and_general_timer
`default_nettype wire

// *** bench/timer_assertions.sv ***
// Purpose: Port assertions for the timers
// Assumes: Register shadows follow APB writes only
// Notes:   Break clears the main enable, so its shadow is trusted only when off
`timescale 1ns/100ps
`default_nettype none
module timer_assertions (
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        nrst_i,
  // Bus
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Pins
  input wire logic        dbg_halt_i,
  input wire logic [15:0] ch_o,
  input wire logic [15:0] ch_oe_o,
  input wire logic [2:0]  chn_o,
  input wire logic        irq_o
);
  // ==========
  // Register shadows
  logic      [15:0] ctrl_ff;
  logic      [5:0]  idle_ff;
  logic      [15:0] ccm_ff;
  logic      [23:0] mask_ff;
  wire logic        wr   = psel_i && penable_i && pwrite_i;
  wire logic        hole = paddr_i[1:0] != 2'h0 || paddr_i[5:0] inside {6'h2c, 6'h38, 6'h3c};
  wire logic        gate = !ctrl_ff[12] || (dbg_halt_i && ctrl_ff[6]);
  logic      [3:0]  oe_exp;
  always_comb for (int c = 0; c < 4; c++) oe_exp[c] = ccm_ff[4*c+3] && ccm_ff[4*c +: 2] == 2'h1;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_ff <= 16'h0000;
      idle_ff <= 6'h00;
      ccm_ff  <= 16'h0000;
      mask_ff <= 24'h000000;
    end else if (wr) begin
      if (paddr_i == 8'h00) ctrl_ff <= pwdata_i[15:0];
      if (paddr_i == 8'h28) idle_ff <= pwdata_i[5:0];
      if (paddr_i == 8'ha0) ccm_ff <= pwdata_i[15:0];
      if (paddr_i[5:0] == 6'h34) mask_ff[6 * paddr_i[7:6] +: 6] <= pwdata_i[5:0];
    end
  end
  // ==========
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_acc;
    psel_i && penable_i;
  endsequence
  sequence s_gate;
    gate && $stable(idle_ff);
  endsequence
  sequence s_safe;
    !(idle_ff[0] && idle_ff[3]) && $stable(idle_ff);
  endsequence
  AST_READY: assert property (pready_o)
    else $error("pready low");
  AST_ERR_MAP: assert property (s_acc |-> pslverr_o == hole)
    else $error("pslverr wrong in access");
  AST_ERR_IDLE: assert property (!penable_i |-> !pslverr_o)
    else $error("pslverr outside access");
  AST_IDLE_MAIN: assert property (s_gate [*3] |-> ch_o[3:0] == idle_ff[3:0])
    else $error("main outputs not idle");
  AST_IDLE_COMP: assert property (s_gate [*3] |-> chn_o == idle_ff[5:3])
    else $error("pair outputs not idle");
  AST_NO_OVL: assert property (s_safe [*2] |-> !(ch_o[0] && chn_o[0]))
    else $error("pair overlap");
  AST_OE: assert property ($stable(ccm_ff) [*2] |-> ch_oe_o[11:8] == oe_exp)
    else $error("enable not following mode");
  AST_IRQ_OFF: assert property ((mask_ff == 24'h0) [*2] |-> !irq_o)
    else $error("irq while masked");
endmodule : timer_assertions
bind advanced_and_general_timer timer_assertions i_timer_assertions (.*);
`default_nettype wire

// *** bench/pin_partner.sv ***
// Purpose: Far-side pins: triggers, break and channel lines
// Assumes: Bench gives the levels the far side wants
// Notes:   Released channel lines take the bench pattern, never the last value
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
  // Bench commands
  input  wire logic [15:0] lvl_i,
  input  wire logic [3:0]  trig_i,
  input  wire logic        brk_cmd_i,
  // Design pins
  input  wire logic [15:0] ch_o,
  input  wire logic [15:0] ch_oe_o,
  output logic      [15:0] ch_in_o,
  output logic      [3:0]  etr_o,
  output logic             brk_o
);
  // Wire level: the design wins where it drives
  assign ch_in_o = (ch_oe_o & ch_o) | (~ch_oe_o & lvl_i);
  assign etr_o = trig_i;
  assign brk_o = brk_cmd_i;
endmodule : pin_partner
`default_nettype wire

// *** bench/testbench.sv ***
// Purpose: Bench for the four timers
// Assumes: Pins come from the partner model
// Notes:   Count steps allow one of slack for prescaler phase
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // ==========
  // Signals
  logic        mclk_i = 1'b0, nrst_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
  logic        pwrite_i = 1'b0, dbg_halt_i = 1'b0, brk_cmd = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [15:0] lvl = 16'h0000;
  logic [3:0]  trig = 4'h0;
  logic [31:0] prdata_o, rd_ff;
  logic        pready_o, pslverr_o, irq_o;
  logic [15:0] ch_o, ch_oe_o, c0;
  logic [2:0]  chn_o;
  logic [3:0]  trgo_o, dma_req_o;
  logic [5:0]  idl;
  wire logic [15:0] ch_i;
  wire logic [3:0]  etr_i;
  wire logic        brk_i;
  int seed, bad_count, compares, cyc, hi, gap, ovl, dma, trg, t0, p, v;
  advanced_and_general_timer i_advanced_and_general_timer (.*);
  pin_partner i_pin_partner (.lvl_i(lvl), .trig_i(trig), .brk_cmd_i(brk_cmd), .ch_o,
    .ch_oe_o, .ch_in_o(ch_i), .etr_o(etr_i), .brk_o(brk_i));
  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) cyc <= cyc + 1;
  // ==========
  // Tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    lvl <= 16'($random(seed));
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    rd_ff = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic watch(input int n);
    {hi, gap, ovl, dma, trg} = '0;
    repeat (n) begin
      @(posedge mclk_i);
      hi += ch_o[8];
      gap += !ch_o[0] && !chn_o[0];
      ovl += ch_o[0] && chn_o[0];
      dma += dma_req_o[1];
      trg += trgo_o[1];
    end
  endtask : watch
  function automatic logic step_ok(input logic [15:0] a, b, input int d, ps, input logic dn);
    int e = d / (ps + 1), got = 16'(dn ? a - b : b - a);
    return got >= e - 1 && got <= e + 1;
  endfunction : step_ok
  task automatic complete_run();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
  // ==========
  // Tests
  initial begin
    seed = 64636;
    repeat (20) @(posedge mclk_i);
    nrst_i <= 1'b1;
    for (int t = 0; t < 4; t++) begin
      apb(0, 8'(t * 64 + 8), 0);
      chk("arr reset", 32'h0000ffff, rd_ff);
    end
    apb(0, 8'h6c, 0);
    for (int i = 0; i < 4; i++) begin
      p = (i == 1) ? 1 + {$random(seed)} % 4 : (i == 2) ? 65535 : 0;
      apb(1, 8'h44, p);
      apb(1, 8'h40, (i == 3) ? 32'h3 : 32'h1);
      apb(0, 8'h4c, 0);
      t0 = cyc;
      c0 = rd_ff[15:0];
      repeat (25 + {$random(seed)} % 16) @(posedge mclk_i);
      apb(0, 8'h4c, 0);
      chk("count step", 1, step_ok(c0, rd_ff[15:0], cyc - t0, p, i == 3));
    end
    v = 4 + {$random(seed)} % 16;
    apb(1, 8'h48, v);
    apb(1, 8'h4c, 0);
    apb(1, 8'h40, 32'h5);
    repeat (6) begin
      apb(0, 8'h4c, 0);
      chk("centre range", 1, rd_ff <= v);
    end
    apb(1, 8'h40, 32'h45);
    dbg_halt_i <= 1'b1;
    apb(0, 8'h4c, 0);
    c0 = rd_ff[15:0];
    repeat (7) @(posedge mclk_i);
    apb(0, 8'h4c, 0);
    chk("frozen count", c0, rd_ff);
    dbg_halt_i <= 1'b0;
    $display("test counting done");
    apb(1, 8'h48, 9);
    apb(1, 8'h40, 32'h81);
    apb(1, 8'h88, 9);
    apb(1, 8'ha0, 9);
    apb(1, 8'h80, 1);
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 0 : (i == 1) ? 10 : 1 + {$random(seed)} % 9;
      apb(1, 8'h90, v);
      watch(20);
      watch(40);
      chk("pwm duty", (v > 9 ? 10 : v) * 4, hi);
      chk("dma rate", 4, dma);
      chk("trigger rate", 4, trg);
    end
    $display("test pwm done");
    v = 1 + {$random(seed)} % 4;
    apb(1, 8'h08, 19);
    apb(1, 8'h10, 10);
    apb(1, 8'h20, 9);
    apb(1, 8'h24, v);
    apb(1, 8'h00, 32'h1001);
    watch(40);
    watch(40);
    chk("dead gap", 4 * v, gap);
    chk("pair overlap", 0, ovl);
    idl = 6'($random(seed));
    apb(1, 8'h28, idl);
    apb(1, 8'h00, 32'h7001);
    brk_cmd <= 1'b1;
    watch(8);
    chk("break main", idl[3:0], ch_o[3:0]);
    chk("break pair", idl[5:3], chn_o);
    chk("masked irq", 0, irq_o);
    apb(1, 8'h34, 32'h20);
    watch(3);
    chk("irq", 1, irq_o);
    brk_cmd <= 1'b0;
    watch(4);
    apb(0, 8'h30, 0);
    chk("break flag", 32'h20, rd_ff & 32'h20);
    watch(3);
    chk("irq cleared", 0, irq_o);
    apb(0, 8'h00, 0);
    chk("main enable", 0, rd_ff[12]);
    apb(1, 8'h00, 32'h1041);
    dbg_halt_i <= 1'b1;
    watch(4);
    chk("frozen pins", {idl[5:3], idl[3:0]}, {chn_o, ch_o[3:0]});
    dbg_halt_i <= 1'b0;
    $display("test advanced done");
    for (int s = 1; s >= 0; s--) begin
      apb(1, 8'h80, 0);
      apb(1, 8'hc0, 0);
      apb(1, 8'hcc, 0);
      apb(1, 8'hc0, s ? 32'h29 : 32'h09);
      watch(20);
      apb(0, 8'hcc, 0);
      chk("held for trigger", 0, rd_ff);
      if (s) apb(1, 8'h80, 1);
      else trig[3] <= 1'b1;
      watch(30);
      apb(0, 8'hcc, 0);
      chk("started by trigger", 1, rd_ff != 0);
      trig[3] <= 1'b0;
    end
    $display("test chaining done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
